// ==== dv/scp_coil_model.sv ====
`timescale 1ns/1ps
module scp_coil_model
  import scp_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bridge drive and target on time
  input  wire scp_gate_t   gate,
  input  wire logic [31:0] on_len,
  // chopper comparator
  output logic             trip
);
  logic [31:0] on_cnt;
  logic        drive_on;

  assign drive_on = gate[3] | gate[2];

  // =====
  // coil current
  // current only climbs while a high side conducts; sense falls back
  // below the reference as soon as the drive stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt <= '0;
      trip   <= 1'b0;
    end else begin
      on_cnt <= drive_on ? on_cnt + 32'h1 : '0;
      trip   <= drive_on && on_cnt >= on_len;
    end
  end
endmodule : scp_coil_model

// ==== dv/stepper_chopper_protection_bench.sv ====
`timescale 1ns/1ps
`include "scp_regs.svh"
module stepper_chopper_protection_bench
  import scp_pkg::*;
;
  localparam int         PWM = 200;
  localparam logic [7:0] CMD = `SCP_CMD_OFS;
  localparam logic [7:0] STA = `SCP_STAT_OFS;
  logic        pclk, presetn, ce, psel, penable, pwrite, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, len_a, len_b;
  logic        pready, pslverr, dis, bsl, bsh, ot, ocla, oclb, high_side_fault;
  logic        trip_a, trip_b, standby;
  logic [11:0] c;
  scp_gate_t   gate_a, gate_b;
  int          fails, compares, n, m, i;

  scp_top #(.PWM_CYC(PWM), .FAST_MAX(100), .LOAD_SHIFT(4)) i_scp_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .disable_pin(dis), .blank_select_low(bsl), .blank_select_high(bsh),
    .overtemp_cmp(ot), .trip_cmp_a(trip_a), .trip_cmp_b(trip_b),
    .ls_oc_cmp_a(ocla), .ls_oc_cmp_b(oclb), .hs_oc_cmp(high_side_fault),
    .gate_a(gate_a), .gate_b(gate_b), .standby(standby));
  scp_coil_model i_scp_coil_model_a (.pclk(pclk), .presetn(presetn),
    .gate(gate_a), .on_len(len_a), .trip(trip_a));
  scp_coil_model i_scp_coil_model_b (.pclk(pclk), .presetn(presetn),
    .gate(gate_b), .on_len(len_b), .trip(trip_b));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // =====
  // helpers
  task test_done;
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task ok(input logic b);
    chk({31'h0, b}, 32'h1);
  endtask : ok

  task gchk(input scp_gate_t g, input scp_gate_t e);
    chk({28'h0, g}, {28'h0, e});
  endtask : gchk

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  // request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(d & mk, e);
  endtask : rd

  task wait_g(input logic b, input scp_gate_t v, output int k);
    k = 0;
    while ((b ? gate_b : gate_a) !== v && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    gchk(b ? gate_b : gate_a, v);
  endtask : wait_g

  // cnt overcurrent pulses, each after blanking; k: 0 low A, 1 low B, 2 high
  task ev(input int k, input int cnt);
    repeat (cnt) begin
      wait_g(k == 1, 4'h9, n);
      cyc(40);
      {ocla, oclb, high_side_fault} <= {k == 0, k == 1, k == 2};
      cyc(1);
      {ocla, oclb, high_side_fault} <= 3'b000;
      cyc(1);
      gchk(k == 1 ? gate_b : gate_a, 4'h0);
      if (k == 2) gchk(gate_b, 4'h0);
    end
  endtask : ev

  // host waits a chopper period plus 10 us after the toggle
  task ld(input logic [31:0] len, input logic [2:0] e);
    len_a = len;
    cyc(3 * PWM);
    c[6] = ~c[6];
    apb(1'b1, CMD, {20'h0, c});
    cyc(3);
    gchk(gate_a, c[6] ? 4'h6 : 4'h9);
    cyc(PWM + 500);
    rd(STA, 32'hE00, {20'h0, e, 9'h0});
    ok((d[11:9] <= 3'd2) == (e <= 3'd2));
    if (e >= 3'd3) ok(d[11:9] >= 3'd3);
  endtask : ld

  // =====
  // watchdog
  initial begin
    #2_000_000;
    fails++;
    test_done;
  end

  // =====
  // tests
  initial begin
    {psel, penable, pwrite, ocla, oclb, high_side_fault, ot, dis, bsl, bsh} = '0;
    {paddr, pwdata, len_a, len_b, fails, compares} = '0;
    {ce, presetn} = 2'b10;
    cyc(4);
    presetn <= 1'b1;
    cyc(1);
    rd(CMD, 32'hFFFFFFFF, 32'h0);
    rd(STA, 32'hFFFFFFFF, 32'h100);
    apb(1'b0, 8'h08, 32'h0);
    chk(d, 32'h0);
    ok(er);
    c = 12'h79E;
    apb(1'b1, CMD, {20'h0, c});
    cyc(2);
    ok(!standby);
    for (i = 0; i < 4; i++) begin
      {bsh, bsl} <= i[1:0];
      wait_g(1'b0, 4'h3, n);
      wait_g(1'b0, 4'h9, n);
      wait_g(1'b0, 4'h3, n);
      ok(n >= 30 + 15 * i && n <= 33 + 15 * i);
    end
    {bsh, bsl} <= 2'b00;
    len_a = 20;
    len_b = 20;
    wait_g(1'b0, 4'h3, n);
    wait_g(1'b0, 4'h9, n);
    wait_g(1'b1, 4'h9, n);
    ok(n >= PWM / 2 - 1 && n <= PWM / 2 + 1);
    apb(1'b1, CMD, 32'h780);
    cyc(PWM);
    gchk(gate_b, 4'h3);
    apb(1'b1, CMD, {20'h0, c | 12'h800});
    len_a = 40;
    cyc(2 * PWM);
    wait_g(1'b0, 4'h2, n);
    wait_g(1'b0, 4'h3, m);
    len_a = 80;
    cyc(2 * PWM);
    wait_g(1'b0, 4'h2, n);
    wait_g(1'b0, 4'h3, n);
    ok(m - n >= 38 && m - n <= 42);
    apb(1'b1, CMD, {20'h0, c});
    len_a = 32'h4000_0000;
    len_b = 32'h4000_0000;
    wait_g(1'b0, 4'h9, n);
    cyc(5);
    ocla <= 1'b1;
    cyc(10);
    ocla <= 1'b0;
    cyc(1);
    gchk(gate_a, 4'h9);
    ev(0, 2);
    cyc(70 * PWM);
    ev(0, 2);
    rd(STA, 32'h1, 32'h0);
    ev(0, 1);
    rd(STA, 32'h1, 32'h1);
    cyc(2 * PWM);
    gchk(gate_a, 4'h0);
    apb(1'b1, STA, 32'h1);
    wait_g(1'b0, 4'h9, n);
    ok(n <= PWM + 2);
    rd(STA, 32'h1, 32'h0);
    ev(1, 3);
    rd(STA, 32'h13, 32'h2);
    wait_g(1'b1, 4'h9, n);
    ok(n >= 61 * PWM && n <= 64 * PWM);
    rd(STA, 32'h2, 32'h2);
    ev(2, 3);
    rd(STA, 32'h10, 32'h10);
    apb(1'b1, CMD, 32'h0);
    cyc(2);
    ok(standby);
    rd(STA, 32'hFFFFFFFF, 32'h100);
    apb(1'b1, CMD, {20'h0, c});
    ot <= 1'b1;
    cyc(3);
    gchk(gate_a | gate_b, 4'h0);
    rd(STA, 32'h80, 32'h80);
    ot <= 1'b0;
    wait_g(1'b0, 4'h9, n);
    rd(STA, 32'h80, 32'h0);
    ld(40, 3'd2);
    ld(100, 3'd6);
    ld(160, 3'd7);
    dis <= 1'b1;
    cyc(3);
    gchk(gate_a | gate_b, 4'h0);
    ok(standby);
    dis <= 1'b0;
    cyc(1);
    rd(CMD, 32'hFFFFFFFF, 32'h0);
    rd(STA, 32'hFFFFFFFF, 32'h100);
    test_done;
  end
endmodule : stepper_chopper_protection_bench

// ==== pkg/scp_flt_if.sv ====
`timescale 1ns/1ps
interface scp_flt_if;
  logic oc_evt;
  logic tick;
  logic clr;
  logic flag;
  logic hold;
  modport cnt (input oc_evt, tick, clr, output flag, hold);
  modport ctl (output oc_evt, tick, clr, input flag, hold);
endinterface : scp_flt_if

// ==== pkg/scp_pkg.sv ====
package scp_pkg;
  // chopper phase of one bridge
  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_ON   = 3'b001,
    CH_FAST = 3'b011,
    CH_SLOW = 3'b010,
    CH_KILL = 3'b110
  } scp_ch_e;
  typedef logic [11:0] scp_word_t;
  // gate order {high1, high2, low1, low2}
  typedef logic [3:0]  scp_gate_t;
endpackage : scp_pkg

// ==== pkg/scp_regs.svh ====
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// ==========================================================
// register byte offsets on apb
`define SCP_CMD_OFS   8'h00
`define SCP_STAT_OFS  8'h04
// ==========================================================
// command word fields
`define SCP_MDA_BIT   11
`define SCP_CA_MSB    10
`define SCP_CA_LSB    7
`define SCP_PHA_BIT   6
`define SCP_MDB_BIT   5
`define SCP_CB_MSB    4
`define SCP_CB_LSB    1
`define SCP_PHB_BIT   0
`define SCP_CMD_RST   12'h000
// ==========================================================
// status word fields
`define SCP_LD_MSB    11
`define SCP_LD_LSB    9
`define SCP_ONE_BIT   8
`define SCP_OT_BIT    7
`define SCP_HIGH_SIDE_FAULT_BIT  4
`define SCP_OCB_BIT   1
`define SCP_OCA_BIT   0
// ==========================================================
// timing
`define SCP_CLK_NS    20
`define SCP_BLANK_NS0 600
`define SCP_BLANK_NS1 900
`define SCP_BLANK_NS2 1200
`define SCP_BLANK_NS3 1500
`define SCP_CYC(ns)   (((ns) + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_OC_TRIPS  3
`define SCP_OC_HOLD   63
`define SCP_OC_QUIET  63
`endif

// ==== rtl/scp_flt.sv ====
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_flt
  import scp_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // fault path
  scp_flt_if.cnt    f
);
  typedef struct packed {
    logic [1:0] trips;
    logic [6:0] quiet;
    logic [5:0] hold;
    logic       flag;
  } scp_flt_s;
  scp_flt_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (f.tick) begin
      if (st_reg.hold != '0) st_next.hold = st_reg.hold - 6'h01;
      if (st_reg.quiet <= 7'(`SCP_OC_QUIET)) begin
        st_next.quiet = st_reg.quiet + 7'h01;
      end
    end
    if (st_reg.quiet > 7'(`SCP_OC_QUIET)) st_next.trips = '0;
    if (f.clr) begin
      st_next.flag  = 1'b0;
      st_next.hold  = '0;
      st_next.trips = '0;
    end
    if (f.oc_evt) begin
      st_next.quiet = '0;
      if (st_reg.trips == 2'(`SCP_OC_TRIPS - 1)) begin
        st_next.trips = '0;
        st_next.flag  = 1'b1;
        st_next.hold  = 6'(`SCP_OC_HOLD);
      end else begin
        st_next.trips = st_reg.trips + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign f.flag = st_reg.flag;
  assign f.hold = st_reg.hold != '0;

  AST_FLT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_reg.flag) |-> st_reg.hold == 6'h3F)
    else $error("flag set without a full hold");
  AST_FLT_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    f.clr && !f.oc_evt |=> !f.flag && !f.hold)
    else $error("clear did not end the shutdown");
  AST_FLT_STICK: assert property (@(posedge pclk) disable iff (!presetn)
    f.flag && !f.clr |=> f.flag)
    else $error("flag dropped without a clear");
endmodule : scp_flt

// ==== rtl/scp_tbase.sv ====
`timescale 1ns/1ps
module scp_tbase
  import scp_pkg::*;
#(
  parameter int PWM_CYC = 1389,
  parameter int CW      = 11
)(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // cycle starts
  output logic      start_a,
  output logic      start_b
);
  localparam logic [CW-1:0] LAST = CW'(PWM_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(PWM_CYC / 2);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } scp_tb_s;
  scp_tb_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.cnt = (st_reg.cnt == LAST) ? '0 : st_reg.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // coil b runs half a period behind coil a
  assign start_a = ce && (st_reg.cnt == '0);
  assign start_b = ce && (st_reg.cnt == HALF);
endmodule : scp_tbase

// ==== rtl/scp_top.sv ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "scp_regs.svh"
// ==========================================================
module scp_top
  import scp_pkg::*;
#(
  parameter int PWM_CYC    = 1389,
  parameter int FAST_MAX   = 347,
  parameter int LOAD_SHIFT = 5
)(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // static pins and comparators
  input  wire logic        disable_pin,
  input  wire logic        blank_select_low,
  input  wire logic        blank_select_high,
  input  wire logic        overtemp_cmp,
  input  wire logic        trip_cmp_a,
  input  wire logic        trip_cmp_b,
  input  wire logic        ls_oc_cmp_a,
  input  wire logic        ls_oc_cmp_b,
  input  wire logic        hs_oc_cmp,
  // bridge gates and mode
  output scp_gate_t        gate_a,
  output scp_gate_t        gate_b,
  output logic             standby
);
  localparam int CW = 11;
  localparam logic [CW-1:0] FMAX = CW'(FAST_MAX);

  if (PWM_CYC < 160 || PWM_CYC > 2047 || FAST_MAX >= PWM_CYC
      || LOAD_SHIFT < 0 || LOAD_SHIFT > 8) begin : g_chk
    $error("scp_top: parameters out of range");
  end

  // ========================================================
  // state
  typedef struct packed {
    scp_word_t          cmd;
    scp_word_t          rdata;
    logic               ot;
    logic               sb;
    logic [2:0]         load;
    logic [1:0]         pol_q;
    scp_ch_e [1:0]      ch;
    logic [1:0][6:0]    blank;
    logic [1:0][CW-1:0] on_cnt;
    logic [1:0][CW-1:0] on_meas;
    logic [1:0][CW-1:0] fast_cnt;
    scp_gate_t [1:0]    gate;
  } scp_top_s;
  scp_top_s st_reg, n;

  logic [1:0][3:0] cur;
  logic [1:0]      pol;
  logic [1:0]      md;
  logic [1:0]      trip;
  logic [1:0]      start;
  logic [1:0]      ls_cmp;
  logic [1:0]      ls_evt;
  logic [1:0]      kill;
  logic [1:0]      off;
  logic [1:0]      blank_on;
  logic [1:0]      pol_chg;
  logic [1:0]      hold_lo;
  logic            hs_evt;
  logic            both_zero;
  logic            apb_setup;
  logic            apb_wr;
  logic            hit;
  logic            zero_wr;
  logic            stat_wr;
  logic [6:0]      blank_len;
  scp_word_t       stat_word;
  scp_word_t       rd_mux;

  // ========================================================
  // helpers
  // fast decay shrinks with on time
  function automatic logic [CW-1:0] fast_len(input logic [CW-1:0] t);
    fast_len = (t >= FMAX) ? '0 : FMAX - t;
  endfunction : fast_len

  // short on time means little back-emf
  function automatic logic [2:0] load_of(input logic [CW-1:0] t);
    logic [CW-1:0] s;
    s = t >> LOAD_SHIFT;
    load_of = (s > CW'(7)) ? 3'h7 : s[2:0];
  endfunction : load_of

  function automatic scp_gate_t gate_of(input scp_ch_e c, input logic p);
    unique case (c)
      CH_ON:            gate_of = p ? 4'h6 : 4'h9;
      CH_FAST:          gate_of = p ? 4'h1 : 4'h2;
      CH_SLOW, CH_IDLE: gate_of = 4'h3;
      default:          gate_of = 4'h0;
    endcase
  endfunction : gate_of

  // ========================================================
  // command decode
  assign cur[0]    = st_reg.cmd[`SCP_CA_MSB:`SCP_CA_LSB];
  assign cur[1]    = st_reg.cmd[`SCP_CB_MSB:`SCP_CB_LSB];
  assign pol[0]    = st_reg.cmd[`SCP_PHA_BIT];
  assign pol[1]    = st_reg.cmd[`SCP_PHB_BIT];
  assign md[0]     = st_reg.cmd[`SCP_MDA_BIT];
  assign md[1]     = st_reg.cmd[`SCP_MDB_BIT];
  assign trip      = {trip_cmp_b, trip_cmp_a};
  assign ls_cmp    = {ls_oc_cmp_b, ls_oc_cmp_a};
  assign both_zero = (cur[0] == 4'h0) && (cur[1] == 4'h0);
  assign pol_chg   = pol ^ st_reg.pol_q;

  always_comb begin
    unique case ({blank_select_high, blank_select_low})
      2'b00: blank_len = 7'(`SCP_CYC(`SCP_BLANK_NS0));
      2'b01: blank_len = 7'(`SCP_CYC(`SCP_BLANK_NS1));
      2'b10: blank_len = 7'(`SCP_CYC(`SCP_BLANK_NS2));
      2'b11: blank_len = 7'(`SCP_CYC(`SCP_BLANK_NS3));
    endcase
  end

  // ========================================================
  // timebase and fault counters
  // shared period, half offset
  scp_tbase #(
    .PWM_CYC (PWM_CYC),
    .CW      (CW)
  ) u_tb (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start_a (start[0]),
    .start_b (start[1])
  );

  scp_flt_if fa ();
  scp_flt_if fb ();
  scp_flt_if fh ();

  for (genvar g = 0; g < 2; g++) begin : g_blank
    assign blank_on[g] = st_reg.blank[g] != '0;
    assign ls_evt[g] = ce && ls_cmp[g] && !blank_on[g] && !disable_pin
                       && st_reg.ch[g] != CH_KILL;
    assign kill[g] = ls_evt[g] || hs_evt;
    // overheat and disable turn all off
    assign off[g] = disable_pin || overtemp_cmp || both_zero
                    || hold_lo[g] || fh.hold;
  end

  assign hs_evt = ce && hs_oc_cmp && !(|blank_on) && !disable_pin
                  && (st_reg.ch[0] != CH_KILL || st_reg.ch[1] != CH_KILL);

  assign apb_setup = ce && psel && !penable;
  assign apb_wr    = ce && psel && penable && pwrite;
  assign hit       = paddr == `SCP_CMD_OFS || paddr == `SCP_STAT_OFS;
  assign stat_wr   = apb_wr && paddr == `SCP_STAT_OFS;
  assign zero_wr   = apb_wr && paddr == `SCP_CMD_OFS
                     && pwdata[`SCP_CA_MSB:`SCP_CA_LSB] == 4'h0
                     && pwdata[`SCP_CB_MSB:`SCP_CB_LSB] == 4'h0;

  assign fa.oc_evt = ls_evt[0];
  assign fb.oc_evt = ls_evt[1];
  assign fh.oc_evt = hs_evt;
  assign fa.tick   = start[0];
  assign fb.tick   = start[1];
  assign fh.tick   = start[0];
  // write one to a flag ends its hold
  assign fa.clr = ce && (disable_pin || zero_wr
                  || (stat_wr && pwdata[`SCP_OCA_BIT]));
  assign fb.clr = ce && (disable_pin || zero_wr
                  || (stat_wr && pwdata[`SCP_OCB_BIT]));
  assign fh.clr = ce && (disable_pin || zero_wr
                  || (stat_wr && pwdata[`SCP_HIGH_SIDE_FAULT_BIT]));
  assign hold_lo = {fb.hold, fa.hold};

  scp_flt u_flt_a (.pclk(pclk), .presetn(presetn), .ce(ce), .f(fa));
  scp_flt u_flt_b (.pclk(pclk), .presetn(presetn), .ce(ce), .f(fb));
  scp_flt u_flt_h (.pclk(pclk), .presetn(presetn), .ce(ce), .f(fh));

  // ========================================================
  // register read
  always_comb begin
    stat_word = '0;
    stat_word[`SCP_LD_MSB:`SCP_LD_LSB] = st_reg.load;
    stat_word[`SCP_ONE_BIT]  = 1'b1;
    stat_word[`SCP_OT_BIT]   = st_reg.ot;
    stat_word[`SCP_HIGH_SIDE_FAULT_BIT] = fh.flag;
    stat_word[`SCP_OCB_BIT]  = fb.flag;
    stat_word[`SCP_OCA_BIT]  = fa.flag;
  end

  always_comb begin
    rd_mux = '0;
    if (paddr == `SCP_CMD_OFS) rd_mux = st_reg.cmd;
    else if (paddr == `SCP_STAT_OFS) rd_mux = stat_word;
  end

  // ========================================================
  // next state
  always_comb begin
    n = st_reg;
    n.ot = overtemp_cmp;
    n.pol_q = pol;
    // read data sampled in setup so prdata comes from a flop
    if (apb_setup) n.rdata = rd_mux;
    if (apb_wr && paddr == `SCP_CMD_OFS) n.cmd = pwdata[11:0];
    for (int i = 0; i < 2; i++) begin
      if (blank_on[i]) n.blank[i] = st_reg.blank[i] - 7'h01;
      if (st_reg.ch[i] == CH_ON && st_reg.on_cnt[i] != '1) begin
        n.on_cnt[i] = st_reg.on_cnt[i] + 1'b1;
      end
      unique case (st_reg.ch[i])
        CH_IDLE, CH_SLOW, CH_KILL: ;
        CH_ON: begin
          if (!blank_on[i] && trip[i]) begin
            n.on_meas[i]  = st_reg.on_cnt[i];
            n.blank[i]    = blank_len;
            n.fast_cnt[i] = fast_len(st_reg.on_cnt[i]);
            n.ch[i] = (md[i] && n.fast_cnt[i] != '0) ? CH_FAST : CH_SLOW;
          end
        end
        CH_FAST: begin
          n.fast_cnt[i] = st_reg.fast_cnt[i] - 1'b1;
          if (st_reg.fast_cnt[i] <= CW'(1)) begin
            n.ch[i]    = CH_SLOW;
            n.blank[i] = blank_len;
          end
        end
        default: n.ch[i] = CH_IDLE;
      endcase
      // zero current parks in slow decay unless both currents are zero
      if (cur[i] == 4'h0) begin
        n.ch[i] = CH_IDLE;
      end else if (start[i] || pol_chg[i]) begin
        n.ch[i]     = CH_ON;
        n.on_cnt[i] = '0;
        n.blank[i]  = blank_len;
      end
      if (kill[i] || off[i]) n.ch[i] = CH_KILL;
      n.gate[i] = gate_of(n.ch[i], pol[i]);
      if (pol_chg[i] && !md[i]) n.load = load_of(st_reg.on_meas[i]);
    end
    if (disable_pin) n = '0;
    n.sb = disable_pin || (n.cmd[`SCP_CA_MSB:`SCP_CA_LSB] == 4'h0
           && n.cmd[`SCP_CB_MSB:`SCP_CB_LSB] == 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= n;
    end
  end

  // ========================================================
  // outputs
  assign prdata  = {20'h00000, st_reg.rdata};
  assign pready  = ce;
  assign pslverr = ce && psel && penable && !hit;
  assign gate_a  = st_reg.gate[0];
  assign gate_b  = st_reg.gate[1];
  assign standby = st_reg.sb;

  // ========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LS_KILL: assert property (
    ls_evt[0] |=> st_reg.ch[0] == CH_KILL ##0 gate_a == 4'h0)
    else $error("low-side overcurrent did not kill bridge a");
  AST_HS_BOTH: assert property (
    hs_evt |=> st_reg.ch[0] == CH_KILL && st_reg.ch[1] == CH_KILL)
    else $error("high-side overcurrent left a bridge on");
  AST_BLANK_MASK: assert property (
    blank_on[1] && ls_oc_cmp_b |-> !fb.oc_evt)
    else $error("low-side event counted during blanking");
  AST_BLANK_LEN: assert property (
    $changed(st_reg.ch[0]) && st_reg.ch[0] == CH_ON
    |-> st_reg.blank[0] == $past(blank_len))
    else $error("blanking not loaded at cycle start");
  AST_POL_RESTART: assert property (
    ce && pol_chg[1] && !off[1] && !kill[1] && cur[1] != 4'h0
    |=> st_reg.ch[1] == CH_ON && st_reg.on_cnt[1] == '0)
    else $error("polarity change did not restart cycle");
  AST_FAST_GATE: assert property (
    st_reg.ch[0] == CH_FAST
    |-> gate_a == (st_reg.pol_q[0] ? 4'h1 : 4'h2))
    else $error("fast decay gates wrong");
  AST_SLOW_GATE: assert property (
    st_reg.ch[1] == CH_SLOW |-> gate_b == 4'h3)
    else $error("slow decay gates wrong");
  AST_MIX_SHORT: assert property (
    $rose(st_reg.ch[0] == CH_FAST)
    |-> st_reg.fast_cnt[0] == fast_len($past(st_reg.on_cnt[0])))
    else $error("fast decay length not tied to on time");
  AST_OT_OFF: assert property (
    ce && overtemp_cmp |=> gate_a == 4'h0 && gate_b == 4'h0)
    else $error("outputs on during overheat");
  AST_DIS_CLR: assert property (
    ce && disable_pin |=> st_reg.cmd == '0 && !fa.flag && !fh.flag
    && gate_a == 4'h0 && standby)
    else $error("disable did not clear state");
  AST_ZERO_CLR: assert property (
    zero_wr && !ls_evt[0] && !hs_evt |=> !fa.flag && !fh.flag)
    else $error("double zero command kept flags");
  AST_LOAD_STEP: assert property (
    ce && !(|pol_chg) && !disable_pin |=> $stable(st_reg.load))
    else $error("load value changed between full steps");

  CVR_KILL: cover property (ls_evt[0] ##1 st_reg.ch[0] == CH_KILL);
  CVR_FLAG: cover property ($rose(fa.flag));
  CVR_FAST: cover property (st_reg.ch[1] == CH_FAST ##1
                            st_reg.ch[1] == CH_SLOW);
  CVR_LOAD: cover property ($changed(st_reg.load));
endmodule : scp_top
